// ===== dv/ccrc_card.sv
// Smart card stand-in that times the card clock it is given.
`timescale 1ns/100ps
module ccrc_card (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Card contact and measurement restart
   input wire logic card_clock_pin,
   input wire logic clr,
   // Last and least half period seen, in system clocks
   output int half,
   output int min_half
);
   logic last;
   int run;
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         last <= 1'b0;
         run <= 0;
         half <= 0;
         min_half <= 99;
      end else begin
         last <= card_clock_pin;
         run <= (card_clock_pin != last) ? 1 : run + 1;
         if (card_clock_pin != last) begin
            half <= run;
         end
         if (clr) begin
            min_half <= 99;
         end else if (card_clock_pin != last && run < min_half) begin
            min_half <= run;
         end
      end
   end
endmodule

// ===== dv/testbench.sv
// Self-checking bench for the card clock and reset control.
`timescale 1ns/100ps
module testbench;
   logic clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, clr = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready, pslverr, card_reset_pin, card_clock_pin;
   int half, min_half, n_errors = 0, n_compared = 0;
   logic [33:0] notes[$];
   ccrc_top #(.ART_CLOCKS(4)) i_dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .card_reset_pin(card_reset_pin), .card_clock_pin(card_clock_pin));
   ccrc_card i_card (.clk(clk), .nrst(nrst), .card_clock_pin(card_clock_pin), .clr(clr), .half(half),
      .min_half(min_half));
   always #12.5 clk = ~clk;
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask
   task automatic results();
      $display("compared %0d, mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // A note is {data checked, error expected, data expected}.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d, input logic [33:0] note);
      notes.push_back(note);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'($urandom), d};
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk iff pready === 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Pins are sampled mid-cycle, away from the edges that move them.
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask
   always @(posedge clk) begin
      if (pready === 1'b1) begin
         if (notes.size() == 0) begin
            check("unasked answer", 32'h0000_0001, 32'h0000_0000);
         end else begin
            check("error flag", {31'h0, pslverr}, {31'h0, notes[0][32]});
            if (notes[0][33]) check("read data", prdata, notes[0][31:0]);
            void'(notes.pop_front());
         end
      end
   end
   initial begin
      logic [7:0] bad;
      int seq[8] = '{0, 1, 2, 3, 6, 7, 4, 5};
      int p, d, lo;
      void'($urandom(32'h9a17));
      bad = {6'($urandom_range(63, 1)), 2'b00};
      repeat (8) @(posedge clk);
      nrst <= 1'b1;
      settle(1);
      check("pins after reset", {30'h0, card_reset_pin, card_clock_pin}, 32'h0000_0000);
      apb(1'b0, 8'h00, 8'h00, {2'b10, 32'h0000_0008});
      apb(1'b1, bad, 8'hff, {2'b01, 32'h0000_0000});
      apb(1'b0, bad, 8'h00, {2'b11, 32'h0000_0000});
      apb(1'b0, 8'h00, 8'h00, {2'b10, 32'h0000_0008});
      $display("test registers done");
      apb(1'b1, 8'h00, 8'h58, {2'b00, 32'h0000_0000});
      apb(1'b0, 8'h00, 8'h00, {2'b10, 32'h0000_0018});
      // Held long enough for the halted-level assertion to see a settled pin.
      settle(75);
      check("held clock high", {31'h0, card_clock_pin}, 32'h0000_0001);
      apb(1'b1, 8'h00, 8'h28, {2'b00, 32'h0000_0000});
      settle(5);
      check("clock level cleared", {31'h0, card_clock_pin}, 32'h0000_0000);
      check("reset held", {31'h0, card_reset_pin}, 32'h0000_0001);
      apb(1'b1, 8'h00, 8'h08, {2'b00, 32'h0000_0000});
      settle(3);
      check("reset cleared", {31'h0, card_reset_pin}, 32'h0000_0000);
      $display("test levels done");
      p = 0;
      for (int i = 0; i < 8; i++) begin
         d = seq[i];
         lo = (ccrc_pkg::DIV_HALF[p] < ccrc_pkg::DIV_HALF[d]) ? ccrc_pkg::DIV_HALF[p] : ccrc_pkg::DIV_HALF[d];
         if (i == 6) begin
            apb(1'b1, 8'h00, 8'h08 | 8'(p), {2'b00, 32'h0000_0000});
            // The halt only takes hold at the end of a high phase, so let the clock stop first.
            settle(40);
            apb(1'b1, 8'h00, 8'h08 | 8'(d), {2'b00, 32'h0000_0000});
         end
         clr <= 1'b1;
         @(posedge clk);
         clr <= 1'b0;
         apb(1'b1, 8'h00, 8'(d), {2'b00, 32'h0000_0000});
         settle(70);
         check("half period", half, 32'(ccrc_pkg::DIV_HALF[d]));
         check("no short phase", {31'h0, min_half >= lo}, 32'h0000_0001);
         p = d;
      end
      $display("test divider done");
      apb(1'b1, 8'h00, 8'h08 | 8'(p), {2'b00, 32'h0000_0000});
      apb(1'b1, 8'h00, 8'ha8, {2'b00, 32'h0000_0000});
      settle(30);
      check("reset while halted", {31'h0, card_reset_pin}, 32'h0000_0000);
      apb(1'b1, 8'h00, 8'ha0, {2'b00, 32'h0000_0000});
      settle(3);
      check("reset before count", {31'h0, card_reset_pin}, 32'h0000_0000);
      settle(20);
      check("reset after count", {31'h0, card_reset_pin}, 32'h0000_0001);
      apb(1'b1, 8'h00, 8'h80, {2'b00, 32'h0000_0000});
      settle(3);
      check("reset dropped", {31'h0, card_reset_pin}, 32'h0000_0000);
      $display("test automatic reset done");
      @(posedge clk);
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      settle(1);
      check("pins after second reset", {30'h0, card_reset_pin, card_clock_pin}, 32'h0000_0000);
      apb(1'b0, 8'h00, 8'h00, {2'b10, 32'h0000_0008});
      $display("test second reset done");
      results();
   end
   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      $display("watchdog expired");
      results();
   end
endmodule

// ===== rtl/ccrc_clkdiv.sv
// Card clock divider with static halt level; glitch-free except that a halt to level 1 leaves a one-cycle low phase.
`timescale 1ns/100ps
module ccrc_clkdiv (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Live settings
   input ccrc_pkg::ccrc_cfg_t cfg,
   // Card clock and its rising-edge pulse
   output logic card_clk,
   output logic rise
);

   logic [4:0] cnt_q, cnt_d;
   logic clk_q, clk_d;
   logic rise_q, rise_d;
   logic [2:0] sel_q, sel_d;
   logic halt_q, halt_d;
   logic [4:0] half;

   // While running, new divider and halt settings are only taken at the end of a high phase, so a divider change
   // never shows a phase on the pin shorter than the shorter of the old and new half periods.
   always_comb begin
      half = ccrc_pkg::DIV_HALF[sel_q];
      cnt_d = cnt_q;
      clk_d = clk_q;
      sel_d = sel_q;
      halt_d = halt_q;
      rise_d = 1'b0;
      if (halt_q) begin
         // A halted pin is static, so settings may change at once.
         cnt_d = '0;
         clk_d = cfg.level;
         sel_d = cfg.div;
         halt_d = cfg.halt;
      end else if (cnt_q == half - 5'd1) begin
         cnt_d = '0;
         clk_d = !clk_q;
         rise_d = !clk_q;
         if (clk_q) begin
            sel_d = cfg.div;
            halt_d = cfg.halt;
         end
      end else begin
         cnt_d = cnt_q + 5'd1;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt_q <= '0;
         clk_q <= 1'b0;
         rise_q <= 1'b0;
         sel_q <= '0;
         halt_q <= 1'b1;
      end else begin
         cnt_q <= cnt_d;
         clk_q <= clk_d;
         rise_q <= rise_d;
         sel_q <= sel_d;
         halt_q <= halt_d;
      end
   end

   assign card_clk = clk_q;
   assign rise = rise_q;

endmodule

// ===== rtl/ccrc_pkg.sv
// Constants, settings layout and timing figures of the card clock and reset control.
package ccrc_pkg;

   // Settings register layout, most significant bit first.
   typedef struct packed {
      logic art;
      logic spare;
      logic hold;
      logic level;
      logic halt;
      logic [2:0] div;
   } ccrc_cfg_t;

   // Register map: one word on the APB.
   localparam logic [7:0] CFG_OFFSET = 8'h00;
   localparam logic [7:0] CFG_RESET = 8'h08;
   localparam int ADDR_W = 8;

   // System clock and card clock limit, in kHz.
   localparam int CLK_KHZ = 40000;
   localparam int CARD_CLK_MAX_KHZ = 24000;
   // Least half period of the card clock in system clocks, rounded up.
   localparam int MIN_HALF = (CLK_KHZ + 2 * CARD_CLK_MAX_KHZ - 1) / (2 * CARD_CLK_MAX_KHZ);

   // Card clock half period in system clocks for each divider setting, setting 0 at the right.
   localparam logic [7:0][4:0] DIV_HALF = {5'd16, 5'd12, 5'd8, 5'd6, 5'd4, 5'd3, 5'd2, 5'd1};

   // Card clock rising edges before the reset pin is released automatically.
   localparam int ART_CLOCKS = 400;

endpackage

// ===== rtl/ccrc_top.sv
// Card clock and reset control with its APB settings register.
//
// Chosen here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
module ccrc_top #(
   parameter int ART_CLOCKS = ccrc_pkg::ART_CLOCKS
) (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ccrc_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Card contacts
   output logic card_reset_pin,
   output logic card_clock_pin
);

   localparam int ART_W = $clog2(ART_CLOCKS + 1);

   // The fastest divider setting must respect the card clock limit.
   if (ccrc_pkg::MIN_HALF > 1 || ART_CLOCKS < 1) begin : g_bad_cfg
      $error("Card clock limit or reset delay cannot be served");
   end

   // APB slave state.
   logic [31:0] prdata_q, prdata_d;
   logic pready_q, pready_d;
   logic pslverr_q, pslverr_d;
   ccrc_pkg::ccrc_cfg_t cfg_q, cfg_d;
   logic access;
   logic done;
   logic hit;

   // Card reset state.
   logic [ART_W-1:0] art_cnt_q, art_cnt_d;
   logic rst_pin_q, rst_pin_d;
   logic card_clk;
   logic card_rise;

   assign access = psel && penable;
   assign done = access && pready_q;
   assign hit = paddr == ccrc_pkg::CFG_OFFSET;

   // One wait state: pready rises in the second access cycle, which keeps prdata registered.
   always_comb begin
      pready_d = access && !pready_q;
      pslverr_d = 1'b0;
      prdata_d = '0;
      cfg_d = cfg_q;
      if (access && !pready_q) begin
         pslverr_d = !hit;
         if (hit && !pwrite) begin
            prdata_d = {24'h00_0000, cfg_q};
         end
      end
      if (done && pwrite && hit) begin
         cfg_d = ccrc_pkg::ccrc_cfg_t'(pwdata[7:0]);
         // The unused bit stores nothing and reads as zero.
         cfg_d.spare = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         prdata_q <= '0;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         cfg_q <= ccrc_pkg::ccrc_cfg_t'(ccrc_pkg::CFG_RESET);
      end else begin
         prdata_q <= prdata_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
         cfg_q <= cfg_d;
      end
   end

   ccrc_clkdiv u_clkdiv (
      .clk(clk),
      .nrst(nrst),
      .cfg(cfg_q),
      .card_clk(card_clk),
      .rise(card_rise)
   );

   // With automatic transition the pin is released after a fixed count of card clock rising
   // edges; a halted card clock therefore also holds the card in reset.
   always_comb begin
      art_cnt_d = art_cnt_q;
      rst_pin_d = rst_pin_q;
      if (!cfg_q.hold) begin
         art_cnt_d = '0;
         rst_pin_d = 1'b0;
      end else if (!cfg_q.art) begin
         rst_pin_d = 1'b1;
      end else if (art_cnt_q == ART_W'(ART_CLOCKS)) begin
         rst_pin_d = 1'b1;
      end else if (card_rise) begin
         art_cnt_d = art_cnt_q + ART_W'(1);
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         art_cnt_q <= '0;
         rst_pin_q <= 1'b0;
      end else begin
         art_cnt_q <= art_cnt_d;
         rst_pin_q <= rst_pin_d;
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign card_reset_pin = rst_pin_q;
   assign card_clock_pin = card_clk;

   // Helper logic for the checks: settings age and card clock phase length.
   localparam int SETTLE = 70;
   logic [6:0] age_q, age_d;
   logic [5:0] run_q, run_d;
   logic prev_q, prev_d;
   logic [4:0] cur_half;

   always_comb begin
      age_d = (cfg_d != cfg_q) ? 7'd0 : ((age_q == 7'd127) ? age_q : age_q + 7'd1);
      prev_d = card_clk;
      run_d = (card_clk != prev_q) ? 6'd0 : ((run_q == 6'd63) ? run_q : run_q + 6'd1);
      cur_half = ccrc_pkg::DIV_HALF[cfg_q.div];
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         age_q <= '0;
         run_q <= '0;
         prev_q <= 1'b0;
      end else begin
         age_q <= age_d;
         run_q <= run_d;
         prev_q <= prev_d;
      end
   end

   a_cfg_reset_value: assert property (@(posedge clk)
      $rose(nrst) |-> cfg_q == ccrc_pkg::ccrc_cfg_t'(ccrc_pkg::CFG_RESET))
      else $error("Settings register left reset with a wrong value");

   a_reset_pin_low: assert property (@(posedge clk) disable iff (!nrst)
      !cfg_q.hold |=> !card_reset_pin)
      else $error("Reset pin not low while reset hold is clear");

   a_reset_pin_direct: assert property (@(posedge clk) disable iff (!nrst)
      cfg_q.hold && !cfg_q.art |=> card_reset_pin)
      else $error("Reset pin not high while hold is set without auto transition");

   a_reset_pin_auto: assert property (@(posedge clk) disable iff (!nrst)
      cfg_q.hold && cfg_q.art && art_cnt_q < ART_W'(ART_CLOCKS) ##1 cfg_q.hold |-> !card_reset_pin)
      else $error("Reset pin released before the auto transition count");

   a_clock_halt_level: assert property (@(posedge clk) disable iff (!nrst)
      age_q >= 7'(SETTLE) && cfg_q.halt |-> card_clock_pin == cfg_q.level)
      else $error("Halted card clock pin does not follow the level bit");

   a_clock_fastest: assert property (@(posedge clk) disable iff (!nrst)
      age_q >= 7'(SETTLE) && !cfg_q.halt && cfg_q.div == 3'd0 |=> card_clock_pin != $past(card_clock_pin))
      else $error("Divider zero does not toggle the card clock every cycle");

   a_div_glitch_free: assert property (@(posedge clk) disable iff (!nrst)
      age_q >= 7'(SETTLE) && !cfg_q.halt && card_clk != prev_q
      |-> run_q == 6'(cur_half) - 6'd1)
      else $error("Card clock phase length differs from the divider setting");

   a_apb_read_data: assert property (@(posedge clk) disable iff (!nrst)
      psel && penable && !pready && !pwrite && paddr == ccrc_pkg::CFG_OFFSET
      |=> pready && prdata == {24'h00_0000, $past(cfg_q)})
      else $error("APB read returned wrong settings value");

endmodule
